//--- design/decoder_pkg.sv
// Constants, field layouts and operation codes of the instruction core.
// Assumes one 125 MHz core clock; four clocks form one instruction cycle.
// Function
// - Byte ops: operation, destination bit, register address
// - 0101/0100/0110 logic with register; Z only
// - 1101/1100 rotate through carry; C only
// - 1011/1111 step register, skip on zero
// - 10bb/11bb test bit, skip clear/set
// - Bit ops: 3-bit index, flags unchanged
// - 111x adds immediate; C, DC, Z
// - 1001/1000/1010 logic with immediate; Z only
// - Immediate minus accumulator; C, DC, Z
// - 01xx returns with immediate, two cycles
// - Word 08 plain return, two cycles
// - Word 09 interrupt return, two cycles
// - Word 64 watchdog restart; TO, PD
// - Word 63 enter standby; TO, PD
// - Port read-modify-write uses pin levels
// - Timer count write clears assigned prescaler, except op 0000 (accumulator move)
// - Taken skip or jump adds NOP cycle
// - One instruction cycle is four clocks
// - Register operand spans 0x00-0x7F of bank
package decoder_pkg;
  // ==========================================
  // Timing
  localparam int CLOCKS_PER_CYCLE = 4;
  localparam logic [1:0] PHASE_FETCH = 2'h0;
  localparam logic [1:0] PHASE_READ = 2'h2;
  localparam logic [1:0] PHASE_EXEC = 2'h3;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic TIMEOUT_RESET = 1'h1;
  localparam logic POWERDOWN_RESET = 1'h1;
  // ==========================================
  // Instruction word fields
  localparam int CLS_MSB = 13;
  localparam int CLS_LSB = 12;
  localparam int OP_MSB = 11;
  localparam int OP_LSB = 8;
  localparam int DEST_BIT = 7;
  localparam int F_MSB = 6;
  localparam int BIT_MSB = 9;
  localparam int BIT_LSB = 7;
  localparam int K8_MSB = 7;
  localparam int K11_MSB = 10;
  localparam int JUMP_SEL_BIT = 11;
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT = 2'h1;
  localparam logic [1:0] CLS_JUMP = 2'h2;
  localparam logic [1:0] CLS_LIT = 2'h3;
  // ==========================================
  // Byte operations
  localparam logic [3:0] OP_MISC = 4'h0;
  localparam logic [3:0] OP_CLR = 4'h1;
  localparam logic [3:0] OP_SUB = 4'h2;
  localparam logic [3:0] OP_DEC = 4'h3;
  localparam logic [3:0] OP_OR = 4'h4;
  localparam logic [3:0] OP_AND = 4'h5;
  localparam logic [3:0] OP_XOR = 4'h6;
  localparam logic [3:0] OP_ADD = 4'h7;
  localparam logic [3:0] OP_MOV = 4'h8;
  localparam logic [3:0] OP_COM = 4'h9;
  localparam logic [3:0] OP_INC = 4'ha;
  localparam logic [3:0] OP_DEC_SKIP = 4'hb;
  localparam logic [3:0] OP_RRC = 4'hc;
  localparam logic [3:0] OP_RLC = 4'hd;
  localparam logic [3:0] OP_SWAP = 4'he;
  localparam logic [3:0] OP_INC_SKIP = 4'hf;
  // Bit operations (two top bits of operation field)
  localparam logic [1:0] BIT_CLEAR = 2'h0;
  localparam logic [1:0] BIT_SET = 2'h1;
  // Literal operations; short forms match the top bits only
  localparam logic [1:0] LIT_MOVE = 2'h0;
  localparam logic [1:0] LIT_RET = 2'h1;
  localparam logic [3:0] LIT_OR = 4'h8;
  localparam logic [3:0] LIT_AND = 4'h9;
  localparam logic [3:0] LIT_XOR = 4'ha;
  localparam logic [2:0] LIT_SUB = 3'h6;
  localparam logic [2:0] LIT_ADD = 3'h7;
  // Fixed control words, low byte with upper bits zero
  localparam logic [7:0] W_RETURN = 8'h08;
  localparam logic [7:0] W_INT_RETURN = 8'h09;
  localparam logic [7:0] W_WDT_RESTART = 8'h64;
  localparam logic [7:0] W_STANDBY = 8'h63;
  // ==========================================
  // Special register addresses
  localparam logic [6:0] TIMER_COUNT_ADDR = 7'h01;
  localparam logic [6:0] IO_FIRST_ADDR = 7'h05;
  localparam logic [6:0] IO_LAST_ADDR = 7'h09;

  typedef enum logic [3:0] {
    ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_RLC, ALU_RRC,
    ALU_DEC, ALU_INC, ALU_COM, ALU_SWAP, ALU_PASS_B, ALU_CLR, ALU_PASS_A
  } alu_op_t;
endpackage

//--- design/alu_unit.sv
// Eight-bit arithmetic and logic unit of the instruction core.
// Assumes the caller picks which flags it keeps.
`timescale 1ns/1ps
module alu_unit (
  input wire decoder_pkg::alu_op_t i_op,
  input wire logic [7:0] i_acc,
  input wire logic [7:0] i_operand,
  input wire logic i_carry,
  output logic [7:0] o_result,
  output logic o_carry,
  output logic o_digit_carry,
  output logic o_zero
);
  logic [8:0] sum;
  logic [4:0] nib;

  always_comb begin
    sum = 9'h000;
    nib = 5'h00;
    o_result = i_acc;
    o_carry = i_carry;
    o_digit_carry = 1'b0;
    case (i_op)
      decoder_pkg::ALU_ADD: begin
        sum = {1'b0, i_acc} + {1'b0, i_operand};
        nib = {1'b0, i_acc[3:0]} + {1'b0, i_operand[3:0]};
      end
      // Carry means no borrow
      decoder_pkg::ALU_SUB: begin
        sum = {1'b0, i_operand} + {1'b0, ~i_acc} + 9'h001;
        nib = {1'b0, i_operand[3:0]} + {1'b0, ~i_acc[3:0]} + 5'h01;
      end
      default: ;
    endcase
    case (i_op)
      decoder_pkg::ALU_ADD, decoder_pkg::ALU_SUB: begin
        o_result = sum[7:0];
        o_carry = sum[8];
        o_digit_carry = nib[4];
      end
      decoder_pkg::ALU_AND: o_result = i_acc & i_operand;
      decoder_pkg::ALU_OR: o_result = i_acc | i_operand;
      decoder_pkg::ALU_XOR: o_result = i_acc ^ i_operand;
      decoder_pkg::ALU_RLC: begin
        o_result = {i_operand[6:0], i_carry};
        o_carry = i_operand[7];
      end
      decoder_pkg::ALU_RRC: begin
        o_result = {i_carry, i_operand[7:1]};
        o_carry = i_operand[0];
      end
      decoder_pkg::ALU_DEC: o_result = i_operand - 8'h01;
      decoder_pkg::ALU_INC: o_result = i_operand + 8'h01;
      decoder_pkg::ALU_COM: o_result = ~i_operand;
      decoder_pkg::ALU_SWAP: o_result = {i_operand[3:0], i_operand[7:4]};
      decoder_pkg::ALU_PASS_B: o_result = i_operand;
      decoder_pkg::ALU_CLR: o_result = 8'h00;
      default: o_result = i_acc;
    endcase
    o_zero = (o_result == 8'h00);
  end
endmodule

//--- design/instruction_core.sv
// Fetch, decode and execute of 14-bit instruction words.
// Assumes program memory and file registers answer within one clock.
`timescale 1ns/1ps
module instruction_core #(
  parameter int STACK_DEPTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [13:0] i_prog_word,
  input wire logic [7:0] i_file_rdata,
  input wire logic [7:0] i_pin_levels,
  input wire logic [1:0] i_bank_sel,
  input wire logic [1:0] i_page_sel,
  input wire logic i_prescaler_to_timer,
  output logic [12:0] o_prog_addr,
  output logic [8:0] o_file_addr,
  output logic [7:0] o_file_wdata,
  output logic o_file_we,
  output logic [7:0] o_acc,
  output logic o_carry,
  output logic o_digit_carry_flag,
  output logic o_zero,
  output logic o_timeout_status,
  output logic o_powerdown_status,
  output logic o_watchdog_restart,
  output logic o_standby,
  output logic o_interrupt_return,
  output logic o_prescaler_clear,
  output logic o_nop_cycle
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  function automatic logic is_io_addr(input logic [6:0] addr);
    return addr >= decoder_pkg::IO_FIRST_ADDR && addr <= decoder_pkg::IO_LAST_ADDR;
  endfunction

  logic [1:0] phase_r;
  logic [13:0] ir_r;
  logic [7:0] operand_r;
  logic flush_r;
  logic [12:0] pc_r;
  logic [12:0] stack_mem [STACK_DEPTH];
  logic [SP_W-1:0] sp_r;

  logic [1:0] cls;
  logic [3:0] op4;
  logic dest_d;
  logic [2:0] bit_idx;
  logic [7:0] k8;
  logic exec;
  decoder_pkg::alu_op_t alu_op;
  logic use_lit, dst_acc, dst_file, upd_c, upd_dc, upd_z;
  logic skip_zero, bit_wr, skip_bit, do_jump, do_call, do_ret;
  logic do_int_ret, do_wdt, do_sleep;
  logic [7:0] alu_b, alu_res, bit_res, result;
  logic alu_c, alu_dc, alu_z, take_two;
  logic [12:0] pc_next;
  logic [12:0] ret_addr;

  assign cls = ir_r[decoder_pkg::CLS_MSB:decoder_pkg::CLS_LSB];
  assign op4 = ir_r[decoder_pkg::OP_MSB:decoder_pkg::OP_LSB];
  assign dest_d = ir_r[decoder_pkg::DEST_BIT];
  assign bit_idx = ir_r[decoder_pkg::BIT_MSB:decoder_pkg::BIT_LSB];
  assign k8 = ir_r[decoder_pkg::K8_MSB:0];
  assign exec = (phase_r == decoder_pkg::PHASE_EXEC) && !flush_r;

  // ==========================================
  // Decode
  always_comb begin
    alu_op = decoder_pkg::ALU_PASS_A;
    use_lit = 1'b0;
    dst_acc = 1'b0;
    dst_file = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    upd_z = 1'b0;
    skip_zero = 1'b0;
    bit_wr = 1'b0;
    skip_bit = 1'b0;
    do_jump = 1'b0;
    do_call = 1'b0;
    do_ret = 1'b0;
    do_int_ret = 1'b0;
    do_wdt = 1'b0;
    do_sleep = 1'b0;
    case (cls)
      decoder_pkg::CLS_BYTE: begin
        dst_acc = !dest_d;
        dst_file = dest_d;
        case (op4)
          decoder_pkg::OP_MISC: begin
            dst_acc = 1'b0;
            if (!dest_d) begin
              do_ret = (k8 == decoder_pkg::W_RETURN);
              do_int_ret = (k8 == decoder_pkg::W_INT_RETURN);
              do_wdt = (k8 == decoder_pkg::W_WDT_RESTART);
              do_sleep = (k8 == decoder_pkg::W_STANDBY);
            end
          end
          decoder_pkg::OP_CLR: begin
            alu_op = decoder_pkg::ALU_CLR;
            upd_z = 1'b1;
          end
          decoder_pkg::OP_SUB, decoder_pkg::OP_ADD: begin
            alu_op = (op4 == decoder_pkg::OP_ADD) ? decoder_pkg::ALU_ADD
                                                  : decoder_pkg::ALU_SUB;
            upd_c = 1'b1;
            upd_dc = 1'b1;
            upd_z = 1'b1;
          end
          decoder_pkg::OP_AND: begin
            alu_op = decoder_pkg::ALU_AND;
            upd_z = 1'b1;
          end
          decoder_pkg::OP_OR: begin
            alu_op = decoder_pkg::ALU_OR;
            upd_z = 1'b1;
          end
          decoder_pkg::OP_XOR: begin
            alu_op = decoder_pkg::ALU_XOR;
            upd_z = 1'b1;
          end
          decoder_pkg::OP_DEC: begin
            alu_op = decoder_pkg::ALU_DEC;
            upd_z = 1'b1;
          end
          decoder_pkg::OP_INC: begin
            alu_op = decoder_pkg::ALU_INC;
            upd_z = 1'b1;
          end
          decoder_pkg::OP_MOV: begin
            alu_op = decoder_pkg::ALU_PASS_B;
            upd_z = 1'b1;
          end
          decoder_pkg::OP_COM: begin
            alu_op = decoder_pkg::ALU_COM;
            upd_z = 1'b1;
          end
          decoder_pkg::OP_DEC_SKIP: begin
            alu_op = decoder_pkg::ALU_DEC;
            skip_zero = 1'b1;
          end
          decoder_pkg::OP_INC_SKIP: begin
            alu_op = decoder_pkg::ALU_INC;
            skip_zero = 1'b1;
          end
          decoder_pkg::OP_RLC: begin
            alu_op = decoder_pkg::ALU_RLC;
            upd_c = 1'b1;
          end
          decoder_pkg::OP_RRC: begin
            alu_op = decoder_pkg::ALU_RRC;
            upd_c = 1'b1;
          end
          decoder_pkg::OP_SWAP: alu_op = decoder_pkg::ALU_SWAP;
          default: ;
        endcase
      end
      decoder_pkg::CLS_BIT: begin
        bit_wr = !op4[3];
        dst_file = !op4[3];
        skip_bit = op4[3];
      end
      decoder_pkg::CLS_JUMP: begin
        do_jump = 1'b1;
        do_call = !ir_r[decoder_pkg::JUMP_SEL_BIT];
      end
      default: begin
        use_lit = 1'b1;
        dst_acc = 1'b1;
        alu_op = decoder_pkg::ALU_PASS_B;
        case (op4)
          decoder_pkg::LIT_OR: begin
            alu_op = decoder_pkg::ALU_OR;
            upd_z = 1'b1;
          end
          decoder_pkg::LIT_AND: begin
            alu_op = decoder_pkg::ALU_AND;
            upd_z = 1'b1;
          end
          decoder_pkg::LIT_XOR: begin
            alu_op = decoder_pkg::ALU_XOR;
            upd_z = 1'b1;
          end
          default: begin
            if (op4[3:2] == decoder_pkg::LIT_RET) begin
              do_ret = 1'b1;
            end else if (op4[3:1] == decoder_pkg::LIT_SUB) begin
              alu_op = decoder_pkg::ALU_SUB;
              upd_c = 1'b1;
              upd_dc = 1'b1;
              upd_z = 1'b1;
            end else if (op4[3:1] == decoder_pkg::LIT_ADD) begin
              alu_op = decoder_pkg::ALU_ADD;
              upd_c = 1'b1;
              upd_dc = 1'b1;
              upd_z = 1'b1;
            end else if (op4[3:2] != decoder_pkg::LIT_MOVE) begin
              dst_acc = 1'b0;
            end
          end
        endcase
      end
    endcase
  end

  assign alu_b = use_lit ? k8 : operand_r;

  alu_unit u_alu (
    .i_op(alu_op),
    .i_acc(o_acc),
    .i_operand(alu_b),
    .i_carry(o_carry),
    .o_result(alu_res),
    .o_carry(alu_c),
    .o_digit_carry(alu_dc),
    .o_zero(alu_z)
  );

  always_comb begin
    bit_res = operand_r;
    bit_res[bit_idx] = op4[2] == decoder_pkg::BIT_SET[0];
  end

  assign result = bit_wr ? bit_res : alu_res;
  assign ret_addr = stack_mem[sp_r - SP_W'(1)];

  assign take_two = do_jump || do_ret || do_int_ret || (skip_zero && alu_z)
                    || (skip_bit && (operand_r[bit_idx] == op4[2]));

  always_comb begin
    pc_next = pc_r + 13'h0001;
    if (do_jump) begin
      pc_next = {i_page_sel, ir_r[decoder_pkg::K11_MSB:0]};
    end else if (do_ret || do_int_ret) begin
      pc_next = ret_addr;
    end else if (take_two) begin
      pc_next = pc_r + 13'h0002;
    end
  end

  // ==========================================
  // Instruction cycle sequencing
  // four clocks per cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      phase_r <= decoder_pkg::PHASE_FETCH;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      flush_r <= 1'b0;
      o_nop_cycle <= 1'b0;
    end else if (phase_r == decoder_pkg::PHASE_EXEC) begin
      flush_r <= exec && take_two;
      o_nop_cycle <= exec && take_two;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      ir_r <= 14'h0000;
      operand_r <= 8'h00;
      o_file_addr <= 9'h000;
    end else if (phase_r == decoder_pkg::PHASE_FETCH) begin
      ir_r <= i_prog_word;
      o_file_addr <= {i_bank_sel, i_prog_word[decoder_pkg::F_MSB:0]};
    end else if (phase_r == decoder_pkg::PHASE_READ) begin
      operand_r <= is_io_addr(ir_r[decoder_pkg::F_MSB:0]) ? i_pin_levels : i_file_rdata;
    end
  end

  // ==========================================
  // Program counter and stack
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      pc_r <= decoder_pkg::PC_RESET;
      o_prog_addr <= decoder_pkg::PC_RESET;
      sp_r <= '0;
    end else if (exec) begin
      pc_r <= pc_next;
      o_prog_addr <= pc_next;
      if (do_call) begin
        sp_r <= sp_r + SP_W'(1);
      end else if (do_ret || do_int_ret) begin
        sp_r <= sp_r - SP_W'(1);
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (exec && do_call) begin
      stack_mem[sp_r] <= pc_r + 13'h0001;
    end
  end

  // ==========================================
  // Results and flags
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_acc <= 8'h00;
      o_carry <= 1'b0;
      o_digit_carry_flag <= 1'b0;
      o_zero <= 1'b0;
    end else if (exec) begin
      if (dst_acc) begin
        o_acc <= result;
      end
      if (upd_c) begin
        o_carry <= alu_c;
      end
      if (upd_dc) begin
        o_digit_carry_flag <= alu_dc;
      end
      if (upd_z) begin
        o_zero <= alu_z;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_file_we <= 1'b0;
      o_file_wdata <= 8'h00;
      o_prescaler_clear <= 1'b0;
    end else begin
      o_file_we <= exec && dst_file;
      if (exec && dst_file) begin
        o_file_wdata <= result;
      end
      o_prescaler_clear <= exec && dst_file && i_prescaler_to_timer
                           && !(cls == decoder_pkg::CLS_BYTE && op4 == decoder_pkg::OP_MISC)
                           && ir_r[decoder_pkg::F_MSB:0] == decoder_pkg::TIMER_COUNT_ADDR;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_timeout_status <= decoder_pkg::TIMEOUT_RESET;
      o_powerdown_status <= decoder_pkg::POWERDOWN_RESET;
      o_watchdog_restart <= 1'b0;
      o_standby <= 1'b0;
      o_interrupt_return <= 1'b0;
    end else begin
      o_watchdog_restart <= exec && do_wdt;
      o_standby <= exec && do_sleep;
      o_interrupt_return <= exec && do_int_ret;
      if (exec && do_wdt) begin
        o_timeout_status <= 1'b1;
        o_powerdown_status <= 1'b1;
      end else if (exec && do_sleep) begin
        o_timeout_status <= 1'b1;
        o_powerdown_status <= 1'b0;
      end
    end
  end

  // ==========================================
  // Assertions
  sequence s_full_cycle;
    phase_r == 2'h1 ##1 phase_r == 2'h2 ##1 phase_r == 2'h3 ##1 phase_r == 2'h0;
  endsequence
  sequence s_nop_cycle;
    flush_r [*4];
  endsequence

  property p_cycle_len;
    @(posedge i_sys_clk) disable iff (i_reset)
      phase_r == 2'h0 |=> s_full_cycle;
  endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("cycle not four clocks");

  property p_taken_nop;
    @(posedge i_sys_clk) disable iff (i_reset)
      exec && take_two |=> s_nop_cycle ##1 !flush_r;
  endproperty
  a_taken_nop: assert property (p_taken_nop) else $error("no NOP cycle");

  property p_dest_file;
    @(posedge i_sys_clk) disable iff (i_reset)
      exec && cls == 2'h0 && dest_d && op4 != 4'h0 |=> o_file_we && o_file_wdata == $past(result);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("no write back");

  property p_dest_acc;
    @(posedge i_sys_clk) disable iff (i_reset)
      exec && cls == 2'h0 && !dest_d && op4 != 4'h0 |=> !o_file_we && o_acc == $past(result);
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("accumulator not written");

  property p_add_flags;
    @(posedge i_sys_clk) disable iff (i_reset)
      exec && alu_op == decoder_pkg::ALU_ADD
        |=> o_carry == $past(alu_c) && o_digit_carry_flag == $past(alu_dc);
  endproperty
  a_add_flags: assert property (p_add_flags) else $error("add flags wrong");

  property p_logic_carry;
    @(posedge i_sys_clk) disable iff (i_reset)
      exec && (alu_op == decoder_pkg::ALU_AND || alu_op == decoder_pkg::ALU_XOR
               || alu_op == decoder_pkg::ALU_OR)
        |=> $stable(o_carry)
            && o_zero == ($past(dst_acc) ? o_acc == 8'h00 : o_file_wdata == 8'h00);
  endproperty
  a_logic_carry: assert property (p_logic_carry) else $error("logic op touched carry");

  property p_rotate_zero;
    @(posedge i_sys_clk) disable iff (i_reset)
      exec && (alu_op == decoder_pkg::ALU_RLC || alu_op == decoder_pkg::ALU_RRC) |=> $stable(o_zero);
  endproperty
  a_rotate_zero: assert property (p_rotate_zero) else $error("rotate touched zero");

  property p_bit_flags;
    @(posedge i_sys_clk) disable iff (i_reset)
      exec && cls == 2'h1 |=> $stable(o_zero) && $stable(o_carry) && $stable(o_digit_carry_flag);
  endproperty
  a_bit_flags: assert property (p_bit_flags) else $error("bit op touched flags");

  property p_standby;
    @(posedge i_sys_clk) disable iff (i_reset)
      exec && do_sleep |=> o_standby && o_timeout_status && !o_powerdown_status;
  endproperty
  a_standby: assert property (p_standby) else $error("standby status wrong");

  property p_clear_zero;
    @(posedge i_sys_clk) disable iff (i_reset)
      exec && alu_op == decoder_pkg::ALU_CLR |=> o_zero;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear left zero low");
endmodule

//--- testbench/prog_mem_model.sv
// Program memory model that supplies 14-bit instruction words.
// Assumes the bench loads the words before reset is released.
`timescale 1ns/1ps
module prog_mem_model (
  input wire logic [12:0] i_addr,
  output logic [13:0] o_word
);
  logic [13:0] mem [0:31];
  // Addresses past the loaded image read as no-operation
  assign o_word = (i_addr < 13'h0020) ? mem[i_addr[4:0]] : 14'h0000;
endmodule

//--- testbench/mid_range_instruction_decoder_test.sv
// Self-checking bench for the instruction core running a short program.
// Assumes four clocks per instruction and reset releasing into phase 0.
`timescale 1ns/1ps
module mid_range_instruction_decoder_test;
  logic i_sys_clk, i_reset;
  logic [13:0] prog_word;
  logic [7:0] file_rdata, pin_levels, file_wdata, acc;
  logic [12:0] prog_addr;
  logic [8:0] file_addr;
  logic file_we, carry, dc, zero, to_st, pd_st, wd_p, sb_p, ir_p, ps_p, nop;
  logic [7:0] fregs [0:127];
  logic presc_asg;
  int error_cnt = 0, checked = 0, step = 0, wd_cnt = 0, sb_cnt = 0, ps_cnt = 0, ir_cnt = 0;
  logic [13:0] prog [0:30] = '{14'h300f, 14'h3e01, 14'h3ef0, 14'h3c05, 14'h390c,
    14'h3830, 14'h3a34, 14'h3011, 14'h07a0, 14'h0ba1, 14'h30ee, 14'h1fa0, 14'h30ee,
    14'h0806, 14'h0d20, 14'h0581, 14'h0064, 14'h0063, 14'h0100, 14'h2018, 14'h201a,
    14'h201c, 14'h281e, 14'h0000, 14'h3442, 14'h0000, 14'h0009, 14'h0000, 14'h0008,
    14'h0000, 14'h0181};

  prog_mem_model pm (.i_addr(prog_addr), .o_word(prog_word));
  instruction_core dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_prog_word(prog_word),
    .i_file_rdata(file_rdata), .i_pin_levels(pin_levels), .i_bank_sel(2'h0),
    .i_page_sel(2'h0), .i_prescaler_to_timer(presc_asg), .o_prog_addr(prog_addr),
    .o_file_addr(file_addr), .o_file_wdata(file_wdata), .o_file_we(file_we), .o_acc(acc),
    .o_carry(carry), .o_digit_carry_flag(dc), .o_zero(zero), .o_timeout_status(to_st),
    .o_powerdown_status(pd_st), .o_watchdog_restart(wd_p), .o_standby(sb_p),
    .o_interrupt_return(ir_p), .o_prescaler_clear(ps_p), .o_nop_cycle(nop));

  // ==========================================
  // Clock, file registers, pulse counters
  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  assign file_rdata = fregs[file_addr[6:0]];
  always @(posedge i_sys_clk) begin
    if (file_we) fregs[file_addr[6:0]] <= file_wdata;
    if (wd_p === 1'b1) wd_cnt++;
    if (sb_p === 1'b1) sb_cnt++;
    if (ps_p === 1'b1) ps_cnt++;
    if (ir_p === 1'b1) ir_cnt++;
  end

  // ==========================================
  // Tasks
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One instruction: wait its cycles, then check accumulator and flags
  task automatic exec(input int cyc, input logic [7:0] w, input logic [2:0] f);
    repeat (4 * cyc - 2) @(negedge i_sys_clk);
    if (cyc == 2) cmp({15'h0, nop}, 16'h0001);
    repeat (2) @(negedge i_sys_clk);
    cmp({8'h00, acc}, {8'h00, w});
    cmp({13'h0, carry, dc, zero}, {13'h0, f});
    step++;
    $display("test step %0d done", step);
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================
  // Watchdog
  initial begin
    repeat (2000) @(posedge i_sys_clk);
    error_cnt++;
    test_done;
  end

  // ==========================================
  // Main sequence
  initial begin
    i_reset = 1'b1;
    pin_levels = 8'h5a;
    presc_asg = 1'b1;
    for (int i = 0; i < 32; i++) pm.mem[i] = (i < 31) ? prog[i] : 14'h0000;
    for (int i = 0; i < 128; i++) fregs[i] = 8'h00;
    fregs[7'h20] = 8'h77;
    fregs[7'h21] = 8'h01;
    fregs[7'h01] = 8'hff;
    repeat (10) @(negedge i_sys_clk);
    cmp({14'h0, to_st, pd_st}, 16'h0003); // status after reset
    i_reset = 1'b0;
    exec(1, 8'h0f, 3'b000); // one cycle
    exec(1, 8'h10, 3'b010); // add immediate
    exec(1, 8'h00, 3'b101); // carry out
    exec(1, 8'h05, 3'b110); // subtract from immediate
    exec(1, 8'h04, 3'b110); // and immediate
    exec(1, 8'h34, 3'b110); // or immediate
    exec(1, 8'h00, 3'b111); // xor immediate
    exec(1, 8'h11, 3'b111); // one cycle
    exec(1, 8'h11, 3'b000); // add to register
    cmp({file_we, file_addr[6:0], file_wdata}, {1'b1, 7'h20, 8'h88}); // destination
    exec(2, 8'h11, 3'b000); // decrement skip
    cmp({8'h00, fregs[7'h21]}, 16'h0000); // decremented value
    cmp({3'h0, prog_addr}, 16'h000b); // skipped word
    exec(2, 8'h11, 3'b000); // bit test skip set
    exec(1, 8'h5a, 3'b000); // pin levels read
    exec(1, 8'h10, 3'b100); // rotate left carry
    exec(1, 8'h10, 3'b100); // and with register
    cmp({file_we, file_addr[6:0], file_wdata}, {1'b1, 7'h01, 8'h10}); // written back
    cmp({15'h0, ps_p}, 16'h0001); // prescaler cleared
    exec(1, 8'h10, 3'b100); // watchdog restart
    cmp({15'h0, wd_p}, 16'h0001); // restart pulse
    exec(1, 8'h10, 3'b100); // standby
    cmp({14'h0, to_st, pd_st}, 16'h0002); // status bits
    cmp({15'h0, sb_p}, 16'h0001); // standby pulse
    exec(1, 8'h00, 3'b101); // clear accumulator
    exec(2, 8'h00, 3'b101); // call
    cmp({3'h0, prog_addr}, 16'h0018); // call target
    exec(2, 8'h42, 3'b101); // return with immediate
    cmp({3'h0, prog_addr}, 16'h0014); // return address
    exec(2, 8'h42, 3'b101); // call
    exec(2, 8'h42, 3'b101); // interrupt return
    cmp({3'h0, prog_addr}, 16'h0015); // return address
    exec(2, 8'h42, 3'b101); // call
    exec(2, 8'h42, 3'b101); // plain return
    cmp({3'h0, prog_addr}, 16'h0016); // return address
    presc_asg = 1'b0;
    exec(2, 8'h42, 3'b101); // jump
    cmp({3'h0, prog_addr}, 16'h001e); // jump target
    exec(1, 8'h42, 3'b101); // clear register
    cmp({file_we, file_addr[6:0], file_wdata}, {1'b1, 7'h01, 8'h00}); // zero written
    cmp({15'h0, ps_p}, 16'h0000); // prescaler not assigned
    repeat (2) @(negedge i_sys_clk);
    cmp({8'h00, fregs[7'h20]}, 16'h0088); // register written
    cmp({8'h00, fregs[7'h01]}, 16'h0000); // register cleared
    cmp({wd_cnt[3:0], sb_cnt[3:0], ps_cnt[3:0], ir_cnt[3:0]}, 16'h1111); // one each
    test_done;
  end
endmodule
